// File: hdl/csel_pkg.sv
// Shared constants and types for the control source selector.
// Assumes a single 10 MHz system clock and an Avalon-MM register bus.
package csel_pkg;

  // ----------------------------------------------------------------
  // Value format
  // ----------------------------------------------------------------
  localparam int VW = 16;
  localparam int AW = 9;

  // ----------------------------------------------------------------
  // Source type codes
  // ----------------------------------------------------------------
  localparam logic [4:0] ST_UNUSED = 5'h00;
  localparam logic [4:0] ST_CAN_RX = 5'h01;
  localparam logic [4:0] ST_UIN    = 5'h02;
  localparam logic [4:0] ST_PID    = 5'h03;
  localparam logic [4:0] ST_LUT    = 5'h04;
  localparam logic [4:0] ST_PLOG   = 5'h05;
  localparam logic [4:0] ST_MATH   = 5'h06;
  localparam logic [4:0] ST_CONST  = 5'h07;
  localparam logic [4:0] ST_CMP    = 5'h08;
  localparam logic [4:0] ST_SR     = 5'h09;
  localparam logic [4:0] ST_DTC    = 5'h0a;
  localparam logic [4:0] ST_TGT    = 5'h0b;
  localparam logic [4:0] ST_FB     = 5'h0c;
  localparam logic [4:0] ST_VSUP   = 5'h0d;
  localparam logic [4:0] ST_TEMP   = 5'h0e;
  localparam logic [4:0] ST_RXTMO  = 5'h0f;
  localparam logic [4:0] ST_CVAR   = 5'h10;
  localparam logic [4:0] ST_DLY    = 5'h11;
  localparam logic [4:0] ST_HYB    = 5'h12;

  // ----------------------------------------------------------------
  // Instance counts and constant numbering
  // ----------------------------------------------------------------
  localparam logic [3:0] N_CAN_RX = 4'h5;
  localparam logic [3:0] N_PAIR   = 4'h2;
  localparam logic [3:0] N_LUT    = 4'h8;
  localparam logic [3:0] N_MATH   = 4'h6;
  localparam logic [3:0] N_DTC    = 4'h5;
  localparam logic [3:0] N_CVAR   = 4'h6;
  localparam logic [3:0] N_SINGLE = 4'h1;
  localparam logic [3:0] N_CONST  = 4'hf;
  localparam logic [3:0] CONST_FALSE = 4'h1;
  localparam logic [3:0] CONST_TRUE  = 4'h2;
  localparam logic [3:0] CONST_USER0 = 4'h3;
  localparam int         N_UCONST    = 13;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0]    SLOT_SEL     = 2'h0;
  localparam logic [1:0]    SLOT_MIN     = 2'h1;
  localparam logic [1:0]    SLOT_MAX     = 2'h2;
  localparam logic [1:0]    SLOT_STAT    = 2'h3;
  localparam logic [AW-1:0] CONST_BASE   = 9'h100;
  localparam logic [AW-1:0] DTC_BASE     = 9'h140;
  localparam logic [AW-1:0] LOG_HEAD_OFF = 9'h180;
  localparam logic [AW-1:0] LOG_RPTR_OFF = 9'h184;
  localparam logic [AW-1:0] LOG_DATA_OFF = 9'h188;
  localparam int            SEL_NUM_LSB  = 8;
  localparam int            SPN_W        = 19;

  // ----------------------------------------------------------------
  // Supported data-link parameter groups
  // ----------------------------------------------------------------
  localparam logic [17:0] PGN_REQUEST  = 18'h0ea00;
  localparam logic [17:0] PGN_ACK      = 18'h0e800;
  localparam logic [17:0] PGN_TP_CM    = 18'h0ec00;
  localparam logic [17:0] PGN_TP_DT    = 18'h0eb00;
  localparam logic [17:0] PGN_PROPB_LO = 18'h0ff00;
  localparam logic [17:0] PGN_PROPB_HI = 18'h0ffff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0][VW-1:0] can_rx;
    logic [1:0][VW-1:0] uin;
    logic [1:0][VW-1:0] pid;
    logic [7:0][VW-1:0] lut;
    logic [1:0]         plog;
    logic [5:0][VW-1:0] math;
    logic [1:0]         cmp;
    logic [1:0]         sr;
    logic [4:0]         dtc;
    logic [1:0][VW-1:0] tgt;
    logic [1:0][VW-1:0] fb_ma;
    logic [VW-1:0]      vsup;
    logic [VW-1:0]      temp;
    logic               rx_tmo;
    logic [5:0][VW-1:0] cvar;
    logic [1:0]         dly;
    logic [1:0]         hyb;
  } csel_src_t;

  typedef struct packed {
    logic [4:0] can_rx;
    logic [1:0] pid;
    logic [1:0] plog;
    logic [5:0] math;
    logic [1:0] cmp;
    logic [1:0] sr;
    logic [1:0] dly;
    logic [1:0] hyb;
  } csel_en_t;

  typedef struct packed {
    logic          valid;
    logic          digital;
    logic [VW-1:0] value;
  } csel_sel_t;

  typedef struct packed {
    logic          valid;
    logic          bit_on;
    logic [VW-1:0] value;
  } csel_out_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_DONE = 3'b100
  } csel_rd_t;

endpackage

// File: hdl/csel_log_mem.sv
// Diagnostic log storage: one write port, registered read port.
// Assumes contents survive logic reset; no reset touches the array.
`timescale 1ns/1ps
module csel_log_mem #(
  parameter int DEPTH = 64,
  parameter int W     = 32,
  parameter int AWL   = $clog2(DEPTH)
) (
  input  wire logic           sys_clk,
  input  wire logic           we,
  input  wire logic [AWL-1:0] waddr,
  input  wire logic [W-1:0]   wdata,
  input  wire logic [AWL-1:0] raddr,
  output logic      [W-1:0]   rdata
);

  logic [W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rdata <= mem[raddr];
  end

endmodule

// File: hdl/csel_top.sv
// Control source selector: routes one coded source to each block input.
// Assumes source values and block enables arrive synchronous to sys_clk.
//
// Overview of operation
// - Source type 0 marks the input unused and disables its other settings.
// - Source is type plus instance; CAN receive type 1, instances 1-5, gated by enable.
// - Type 6 picks math block 1-6, type 4 lookup 1-8, type 2 input 1-2.
// - Type 7 constants 1-15: 1 false, 2 true, 3-15 user values.
// - Type 10 picks DTC state 1-5, valid only with non-zero SPN.
// - Types 12, 13, 14 give feedback current, supply voltage, processor temperature.
// - Types 16,17,18,3,5,8,9,11 pick variables, timers, hysteresis, PID, logic, etc.
// - All types offered to every input except reception timeout, withheld from some.
// - Analog to digital: off at/below minimum, on at/above maximum, else hold.
// - Recognise request, acknowledge, transport and proprietary B parameter groups.
// - Diagnostic events go into a log that reset does not clear.
`timescale 1ns/1ps
module csel_top
  import csel_pkg::*;
#(
  parameter int               N_SLOT    = 8,
  parameter logic [N_SLOT-1:0] TMO_MASK = 8'h7f,
  parameter int               LOG_DEPTH = 64
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic [AW-1:0]         address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  input  wire csel_src_t             sources,
  input  wire csel_en_t              enables,
  output csel_out_t [N_SLOT-1:0]     slot_out,
  input  wire logic                  diag_evt,
  input  wire logic [31:0]           diag_code,
  input  wire logic                  pgn_q_valid,
  input  wire logic [17:0]           pgn_query,
  output logic                       pgn_ok,
  output logic                       pgn_done
);

  localparam int LAW = $clog2(LOG_DEPTH);

  logic [N_SLOT-1:0][4:0]        sl_type;
  logic [N_SLOT-1:0][3:0]        sl_num;
  logic [N_SLOT-1:0][VW-1:0]     sl_min;
  logic [N_SLOT-1:0][VW-1:0]     sl_max;
  csel_sel_t [N_SLOT-1:0]        sel_w;
  logic [N_UCONST-1:0][VW-1:0]   uconst;
  logic [4:0][SPN_W-1:0]         dtc_spn;
  logic [4:0]                    spn_ok;
  logic [LAW-1:0]                log_head;
  logic [LAW:0]                  log_count;
  logic [LAW-1:0]                log_rptr;
  logic [31:0]                   log_q;
  logic [31:0]                   next_rdata;
  logic [3:0]                    sidx;
  logic                          slot_hit;
  logic                          head_wr;
  csel_rd_t                      rd_state;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [3:0] n, input logic [3:0] top);
    return (n != 4'h0) && (n <= top);
  endfunction

  function automatic csel_sel_t pick(input logic [4:0] t, input logic [3:0] n,
                                     input csel_src_t s, input csel_en_t e,
                                     input logic [N_UCONST-1:0][VW-1:0] k,
                                     input logic [4:0] sok, input logic tmo_ok);
    csel_sel_t  r;
    logic [3:0] i;
    r = '0;
    i = n - 4'h1;
    case (t)
      ST_CAN_RX: if (in_rng(n, N_CAN_RX)) r = '{e.can_rx[i[2:0]], 1'b0, s.can_rx[i[2:0]]};
      ST_UIN:    if (in_rng(n, N_PAIR))   r = '{1'b1, 1'b0, s.uin[i[0]]};
      ST_LUT:    if (in_rng(n, N_LUT))    r = '{1'b1, 1'b0, s.lut[i[2:0]]};
      ST_MATH:   if (in_rng(n, N_MATH))   r = '{e.math[i[2:0]], 1'b0, s.math[i[2:0]]};
      ST_PID:    if (in_rng(n, N_PAIR))   r = '{e.pid[i[0]], 1'b0, s.pid[i[0]]};
      ST_PLOG:   if (in_rng(n, N_PAIR))   r = '{e.plog[i[0]], 1'b1, 16'(s.plog[i[0]])};
      ST_CMP:    if (in_rng(n, N_PAIR))   r = '{e.cmp[i[0]], 1'b1, 16'(s.cmp[i[0]])};
      ST_SR:     if (in_rng(n, N_PAIR))   r = '{e.sr[i[0]], 1'b1, 16'(s.sr[i[0]])};
      ST_TGT:    if (in_rng(n, N_PAIR))   r = '{1'b1, 1'b0, s.tgt[i[0]]};
      ST_CVAR:   if (in_rng(n, N_CVAR))   r = '{1'b1, 1'b0, s.cvar[i[2:0]]};
      ST_DLY:    if (in_rng(n, N_PAIR))   r = '{e.dly[i[0]], 1'b1, 16'(s.dly[i[0]])};
      ST_HYB:    if (in_rng(n, N_PAIR))   r = '{e.hyb[i[0]], 1'b1, 16'(s.hyb[i[0]])};
      ST_DTC:    if (in_rng(n, N_DTC))    r = '{sok[i[2:0]], 1'b1, 16'(s.dtc[i[2:0]])};
      ST_FB:     if (in_rng(n, N_PAIR))   r = '{1'b1, 1'b0, s.fb_ma[i[0]]};
      ST_VSUP:   if (n == N_SINGLE)       r = '{1'b1, 1'b0, s.vsup};
      ST_TEMP:   if (n == N_SINGLE)       r = '{1'b1, 1'b0, s.temp};
      ST_RXTMO:  if (n == N_SINGLE)       r = '{tmo_ok, 1'b1, 16'(s.rx_tmo)};
      ST_CONST:
      begin
        if (n == CONST_FALSE)
          r = '{1'b1, 1'b1, 16'h0000};
        else if (n == CONST_TRUE)
          r = '{1'b1, 1'b1, 16'h0001};
        else if (n >= CONST_USER0 && n <= N_CONST)
          r = '{1'b1, 1'b1, k[n - CONST_USER0]};
      end
      default:   r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  assign sidx     = address[7:4];
  assign slot_hit = !address[8] && (32'(sidx) < N_SLOT);
  assign head_wr  = write && address == LOG_HEAD_OFF;

  // ----------------------------------------------------------------
  // Per-slot configuration, selection and hysteresis
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N_SLOT; g++)
  begin : g_slot
    logic hys;
    logic next_hys;

    always_ff @(posedge sys_clk)
    begin
      if (!reset_n)
      begin
        sl_type[g] <= ST_UNUSED;
        sl_num[g]  <= 4'h0;
        sl_min[g]  <= 16'h0000;
        sl_max[g]  <= 16'h0000;
      end
      else if (write && slot_hit && 32'(sidx) == g)
      begin
        case (address[3:2])
          SLOT_SEL:
          begin
            sl_type[g] <= 5'(be_merge({20'h0, sl_num[g], 3'h0, sl_type[g]}, writedata, byteenable));
            sl_num[g]  <= 4'(be_merge({20'h0, sl_num[g], 3'h0, sl_type[g]}, writedata, byteenable) >> 8);
          end
          SLOT_MIN:
            if (sl_type[g] != ST_UNUSED)
              sl_min[g] <= 16'(be_merge(32'(sl_min[g]), writedata, byteenable));
          SLOT_MAX:
            if (sl_type[g] != ST_UNUSED)
              sl_max[g] <= 16'(be_merge(32'(sl_max[g]), writedata, byteenable));
          default:  ;
        endcase
      end
    end

    assign sel_w[g] = pick(sl_type[g], sl_num[g], sources, enables, uconst, spn_ok, TMO_MASK[g]);

    always_comb
    begin
      next_hys = hys;
      if (sel_w[g].value <= sl_min[g])
        next_hys = 1'b0;
      else if (sel_w[g].value >= sl_max[g])
        next_hys = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
      if (!reset_n || sl_type[g] == ST_UNUSED || !sel_w[g].valid)
        hys <= 1'b0;
      else if (!sel_w[g].digital)
        hys <= next_hys;
    end

    always_ff @(posedge sys_clk)
    begin
      if (!reset_n || sl_type[g] == ST_UNUSED)
        slot_out[g] <= '0;
      else
      begin
        slot_out[g].valid  <= sel_w[g].valid;
        slot_out[g].value  <= sel_w[g].valid ? sel_w[g].value : 16'h0000;
        slot_out[g].bit_on <= sel_w[g].valid &&
                              (sel_w[g].digital ? (sel_w[g].value != 16'h0000) : next_hys);
      end
    end
  end

  // ----------------------------------------------------------------
  // User constants and DTC parameter numbers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      uconst  <= '0;
      dtc_spn <= '0;
    end
    else if (write)
    begin
      for (int c = 0; c < N_UCONST; c++)
        if (address == CONST_BASE + 9'(c * 4))
          uconst[c] <= 16'(be_merge(32'(uconst[c]), writedata, byteenable));
      for (int d = 0; d < 5; d++)
        if (address == DTC_BASE + 9'(d * 4))
          dtc_spn[d] <= SPN_W'(be_merge(32'(dtc_spn[d]), writedata, byteenable));
    end
  end

  for (genvar d = 0; d < 5; d++)
  begin : g_spn
    assign spn_ok[d] = dtc_spn[d] != '0;
  end

  // ----------------------------------------------------------------
  // Parameter group recognition
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pgn_ok   <= 1'b0;
      pgn_done <= 1'b0;
    end
    else
    begin
      pgn_done <= pgn_q_valid;
      pgn_ok   <= pgn_q_valid && (pgn_query == PGN_REQUEST || pgn_query == PGN_ACK ||
                  pgn_query == PGN_TP_CM || pgn_query == PGN_TP_DT ||
                  (pgn_query >= PGN_PROPB_LO && pgn_query <= PGN_PROPB_HI));
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic log
  // ----------------------------------------------------------------
  csel_log_mem #(
    .DEPTH (LOG_DEPTH),
    .W     (32)
  ) u_log (
    .sys_clk (sys_clk),
    .we      (diag_evt),
    .waddr   (head_wr ? writedata[LAW-1:0] : log_head),
    .wdata   (diag_code),
    .raddr   (log_rptr),
    .rdata   (log_q)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      log_head  <= '0;
      log_count <= '0;
    end
    else
    begin
      if (diag_evt)
        log_head <= (head_wr ? writedata[LAW-1:0] : log_head) + 1'b1;
      else if (head_wr)
        log_head <= writedata[LAW-1:0];
      if (head_wr)
        log_count <= writedata[16 +: LAW+1];
      else if (diag_evt && 32'(log_count) < LOG_DEPTH)
        log_count <= log_count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      log_rptr <= '0;
    else if (write && address == LOG_RPTR_OFF)
      log_rptr <= writedata[LAW-1:0];
    else if (rd_state == RD_DONE && read && address == LOG_DATA_OFF)
      log_rptr <= log_rptr + 1'b1;
  end

  // ----------------------------------------------------------------
  // Register bus read path
  // ----------------------------------------------------------------
  assign waitrequest = read && rd_state != RD_DONE;

  always_comb
  begin
    next_rdata = 32'h0;
    if (slot_hit)
    begin
      case (address[3:2])
        SLOT_SEL:  next_rdata = {20'h0, sl_num[sidx], 3'h0, sl_type[sidx]};
        SLOT_MIN:  next_rdata = 32'(sl_min[sidx]);
        SLOT_MAX:  next_rdata = 32'(sl_max[sidx]);
        default:   next_rdata = {slot_out[sidx].value, 14'h0, slot_out[sidx].bit_on, slot_out[sidx].valid};
      endcase
    end
    else if (address == LOG_HEAD_OFF)
      next_rdata = {16'(log_count), 16'(log_head)};
    else if (address == LOG_RPTR_OFF)
      next_rdata = 32'(log_rptr);
    else if (address == LOG_DATA_OFF)
      next_rdata = log_q;
    else
    begin
      for (int c = 0; c < N_UCONST; c++)
        if (address == CONST_BASE + 9'(c * 4))
          next_rdata = 32'(uconst[c]);
      for (int d = 0; d < 5; d++)
        if (address == DTC_BASE + 9'(d * 4))
          next_rdata = 32'(dtc_spn[d]);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rd_state <= RD_IDLE;
      readdata <= 32'h0;
    end
    else
    begin
      case (rd_state)
        RD_IDLE: if (read) rd_state <= RD_WAIT;
        RD_WAIT:
        begin
          readdata <= next_rdata;
          rd_state <= RD_DONE;
        end
        RD_DONE: rd_state <= RD_IDLE;
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  unused_slot_clear_a: assert property (sl_type[0] == ST_UNUSED |=> !slot_out[0].valid && !slot_out[0].bit_on)
    else $error("unused input still drives");
  can_rx_gate_a: assert property (sl_type[0] == ST_CAN_RX && sl_num[0] == 4'h1 && !enables.can_rx[0]
    |=> !slot_out[0].valid) else $error("disabled receive block passed");
  math_range_a: assert property (sl_type[0] == ST_MATH && sl_num[0] > 4'h6 |=> !slot_out[0].valid)
    else $error("math instance out of range accepted");
  const_true_a: assert property (sl_type[0] == ST_CONST && sl_num[0] == 4'h2
    |=> slot_out[0].valid && slot_out[0].bit_on && slot_out[0].value == 16'h0001) else $error("true constant wrong");
  dtc_spn_zero_a: assert property (sl_type[0] == ST_DTC && sl_num[0] == 4'h1 && dtc_spn[0] == '0
    |=> !slot_out[0].valid) else $error("DTC without SPN accepted");
  supply_pass_a: assert property (sl_type[0] == ST_VSUP && sl_num[0] == 4'h1
    |=> slot_out[0].valid && slot_out[0].value == $past(sources.vsup)) else $error("supply value not routed");
  cvar_pick_a: assert property (sl_type[0] == ST_CVAR && sl_num[0] == 4'h6
    |=> slot_out[0].value == $past(sources.cvar[5])) else $error("control variable misrouted");
  tmo_withheld_a: assert property (sl_type[N_SLOT-1] == ST_RXTMO && !TMO_MASK[N_SLOT-1]
    |=> !slot_out[N_SLOT-1].valid) else $error("timeout offered to withheld input");
  hyst_hold_a: assert property (sel_w[1].valid && !sel_w[1].digital && sel_w[1].value > sl_min[1]
    && sel_w[1].value < sl_max[1] && $stable(sl_type[1]) && $past(sel_w[1].valid)
    |=> slot_out[1].bit_on == $past(slot_out[1].bit_on)) else $error("hysteresis did not hold");
  hyst_on_a: assert property (sel_w[0].valid && !sel_w[0].digital && sel_w[0].value >= sl_max[0]
    && sel_w[0].value > sl_min[0] |=> slot_out[0].bit_on) else $error("analog at maximum not on");
  pgn_request_a: assert property (pgn_q_valid && pgn_query == PGN_REQUEST |=> pgn_done && pgn_ok)
    else $error("request group not recognised");
  log_advance_a: assert property (diag_evt && !head_wr |=> log_head == LAW'($past(log_head) + 1'b1))
    else $error("log head did not advance");
  hyst_start_a: assert property ($rose(reset_n) |-> !slot_out[0].bit_on)
    else $error("output on right after reset");

  slot_on_c: cover property (slot_out[0].valid && slot_out[0].bit_on);
  log_read_c: cover property (read && !waitrequest && address == LOG_DATA_OFF);
  pgn_ok_c: cover property (pgn_done && pgn_ok);
  const_user_c: cover property (sl_type[0] == ST_CONST && sl_num[0] == 4'h5 ##1 slot_out[0].valid);

endmodule

// File: tb/csel_blocks.sv
// Far-side block model: sources and block enables for the selector.
// Assumes one analog level, one digital level and one enable from the bench.
`timescale 1ns/1ps
module csel_blocks
  import csel_pkg::*;
(
  input  wire logic [VW-1:0] ana,
  input  wire logic          dig,
  input  wire logic          en,
  output csel_src_t          sources,
  output csel_en_t           enables
);
  // Field order follows the packed source struct
  assign sources = {{17{ana}}, {2{dig}}, {6{ana}}, {9{dig}}, {6{ana}}, dig, {6{ana}}, {4{dig}}};
  assign enables = {$bits(csel_en_t){en}};
endmodule

// File: tb/testbench.sv
// Bench: bus tests of source choice, thresholds, parameter groups and log.
// Assumes csel_top defaults and csel_blocks on the source side.
`timescale 1ns/1ps
module testbench
  import csel_pkg::*;
;
  logic            sys_clk = 0, reset_n = 0, read = 0, write = 0, diag_evt = 0, pgn_q_valid = 0, en = 0, dig = 1;
  logic [AW-1:0]   address = '0;
  logic [31:0]     writedata = '0, diag_code = 32'hc0de5a5a, q, readdata;
  logic [17:0]     pgn_query = '0;
  logic [VW-1:0]   ana = 16'h0050;
  logic [3:0]      be = 4'hf;
  logic            waitrequest, pgn_ok, pgn_done;
  csel_src_t       sources;
  csel_en_t        enables;
  csel_out_t [7:0] slot_out;
  int              error_cnt = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] A = 32'h00500001, M = 32'hffff0001, F = 32'hffffffff;
  logic [17:0]     pg [8] = '{18'h0ea00, 18'h0e800, 18'h0ec00, 18'h0eb00, 18'h0ff00, 18'h0ffff, 18'h0feff, 18'h0ea01};
  logic            pe [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  csel_blocks u_csel_blocks (.ana, .dig, .en, .sources, .enables);
  csel_top u_csel_top (.sys_clk, .reset_n, .address, .read, .write, .writedata, .byteenable(be), .readdata,
    .waitrequest, .sources, .enables, .slot_out, .diag_evt, .diag_code, .pgn_q_valid, .pgn_query, .pgn_ok,
    .pgn_done);
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  task results;
    if (cyc >= 20000) error_cnt++;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
      results();
  end
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Avalon cycle: hold until waitrequest low, then release
  task bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task sc(input int s, input logic [4:0] t, input logic [3:0] n, input logic [31:0] e, input logic [31:0] m);
    bus(1, 9'(16 * s), {20'h0, n, 3'h0, t});
    bus(0, 9'(16 * s + 12), 0);
    cmp("status", e, q & m);
  endtask
  task pq(input logic [17:0] g, input logic e);
    @(posedge sys_clk);
    pgn_query <= g;
    pgn_q_valid <= 1'b1;
    @(posedge sys_clk);
    pgn_q_valid <= 1'b0;
    @(negedge sys_clk);
    cmp("pgn", {30'h0, 1'b1, e}, {30'h0, pgn_done, pgn_ok});
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(0, 9'h1f0, 0);
    cmp("unmapped", 0, q);
    sc(0, ST_UNUSED, 4'h0, 0, F);
    sc(0, ST_CAN_RX, 4'h1, 0, F);
    en <= 1'b1;
    sc(0, ST_CAN_RX, N_CAN_RX, A, M);
    sc(0, ST_CAN_RX, 4'h6, 0, F);
    sc(0, ST_MATH, N_MATH, A, M);
    sc(0, ST_MATH, 4'h7, 0, F);
    sc(0, ST_LUT, N_LUT, A, M);
    sc(0, ST_UIN, 4'h3, 0, F);
    sc(0, ST_CONST, CONST_FALSE, 1, 3);
    sc(0, ST_CONST, CONST_TRUE, 3, 3);
    bus(1, CONST_BASE, 32'h1234);
    sc(0, ST_CONST, CONST_USER0, 32'h12340001, M);
    be <= 4'h1;
    bus(1, CONST_BASE, F);
    be <= 4'hf;
    sc(0, ST_CONST, CONST_USER0, 32'h12ff0001, M);
    sc(0, ST_DTC, 4'h1, 0, F);
    bus(1, DTC_BASE, 1);
    sc(0, ST_DTC, 4'h1, 3, 3);
    sc(0, ST_FB, 4'h2, A, M);
    sc(0, ST_VSUP, 4'h1, A, M);
    sc(0, ST_TEMP, 4'h1, A, M);
    sc(0, ST_CVAR, N_CVAR, A, M);
    sc(0, ST_DLY, 4'h2, 3, 3);
    sc(0, ST_PID, 4'h2, A, M);
    sc(0, ST_TGT, 4'h2, A, M);
    sc(0, ST_PLOG, 4'h1, 3, 3);
    sc(0, ST_CMP, 4'h2, 3, 3);
    sc(0, ST_SR, 4'h1, 3, 3);
    sc(0, ST_HYB, 4'h2, 3, 3);
    sc(0, ST_UNUSED, 4'h5, 0, F);
    sc(6, ST_RXTMO, 4'h1, 3, 3);
    sc(7, ST_RXTMO, 4'h1, 0, F);
    $display("test source selection done");
    ana <= 16'h0000;
    sc(1, ST_UIN, 4'h1, 32'h00000001, F);
    bus(1, 9'h014, 32'h0100);
    bus(1, 9'h018, 32'h0200);
    ana <= 16'h0150;
    sc(1, ST_UIN, 4'h1, 32'h01500001, F);
    ana <= 16'h0200;
    sc(1, ST_UIN, 4'h1, 32'h02000003, F);
    ana <= 16'h0150;
    sc(1, ST_UIN, 4'h1, 32'h01500003, F);
    ana <= 16'h0100;
    sc(1, ST_UIN, 4'h1, 32'h01000001, F);
    foreach (pg[i]) pq(pg[i], pe[i]);
    $display("test hysteresis and groups done");
    @(posedge sys_clk);
    diag_evt <= 1'b1;
    @(posedge sys_clk);
    diag_evt <= 1'b0;
    bus(0, LOG_HEAD_OFF, 0);
    cmp("log head", 32'h00010001, q);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(0, LOG_HEAD_OFF, 0);
    cmp("log head", 0, q);
    bus(0, LOG_DATA_OFF, 0);
    cmp("log data", diag_code, q);
    bus(0, LOG_RPTR_OFF, 0);
    cmp("log rptr", 1, q);
    bus(1, LOG_HEAD_OFF, 32'h00010001);
    bus(0, LOG_HEAD_OFF, 0);
    cmp("log head", 32'h00010001, q);
    $display("test log done");
    results();
  end
endmodule
